// File: common/vac_pkg.sv
// constants, types and register map of the vc arbitration configuration block
`default_nettype none
package vac_pkg;
  // ****************************************************************
  // register map (byte addresses in extended configuration space)
  // ****************************************************************
  localparam logic [11:0] VAC_CAP_ADDR = 12'h158;
  localparam logic [11:0] VAC_CTRL_ADDR = 12'h15C;
  localparam logic [11:0] VAC_STAT_ADDR = 12'h15E;
  localparam logic [11:0] VAC_DWORD_MASK = 12'hFFC;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int VAC_LOC_LSB = 24;
  localparam int VAC_MASK_LSB = 0;
  localparam int VAC_CTRL_LSB = 0;
  localparam int VAC_STAT_LSB = 16;
  localparam int VAC_COMMIT_BIT = 0;
  localparam int VAC_CHOICE_LSB = 1;
  localparam int VAC_CHOICE_MSB = 3;
  localparam int VAC_DIRTY_BIT = 0;
  localparam int VAC_CTRL_BYTE = 0;
  // ****************************************************************
  // field values
  // ****************************************************************
  localparam logic [7:0] VAC_LOC_USED = 8'h03;
  localparam logic [7:0] VAC_LOC_NONE = 8'h00;
  localparam logic [7:0] VAC_MASK_FULL = 8'h03;
  localparam logic [7:0] VAC_MASK_NONE = 8'h00;
  localparam logic [2:0] VAC_PRIO_NORMAL = 3'h1;
  localparam logic [2:0] VAC_PRIO_STRICT = 3'h0;
  localparam logic [2:0] VAC_CHOICE_FIXED_RR = 3'h0;
  localparam logic [2:0] VAC_CHOICE_WRR32 = 3'h1;
  localparam logic [2:0] VAC_CHOICE_RESET = VAC_CHOICE_FIXED_RR;
  localparam logic [31:0] VAC_ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] VAC_ZERO_HALF = 16'h0000;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [3:0] be;
    logic [31:0] wdata;
  } vac_cfg_req_s;
  typedef enum logic [0:0] {
    VAC_COPY_IDLE,
    VAC_COPY_BUSY
  } vac_copy_e;
endpackage
`default_nettype wire

// File: hw/vac_arbitration_config.sv
// vc arbitration capability, control and status registers with table commit tracking
`default_nettype none
module vac_arbitration_config (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire vac_pkg::vac_cfg_req_s I_CFG_REQ,
  output logic [31:0] O_CFG_RDATA,
  output logic O_CFG_RVALID,
  input wire logic I_STRICT_PRIO_EN,
  input wire logic I_TABLE_ENTRY_WRITE,
  output logic O_TABLE_COPY_START,
  input wire logic I_TABLE_COPY_DONE,
  output logic [2:0] O_ARB_SCHEME_CHOICE,
  output logic O_ARB_TABLE_IN_USE,
  output logic [2:0] O_LOW_PRIO_EXT_CHANNEL_COUNT
);
  // ****************************************************************
  // capability values
  // ****************************************************************
  logic [2:0] low_prio_ext_channel_count;
  logic [7:0] arb_table_location;
  logic [7:0] arb_scheme_mask;
  logic table_used;
  always_comb begin
    low_prio_ext_channel_count = I_STRICT_PRIO_EN ? vac_pkg::VAC_PRIO_STRICT : vac_pkg::VAC_PRIO_NORMAL;
    table_used = (low_prio_ext_channel_count != vac_pkg::VAC_PRIO_STRICT);
    arb_table_location = table_used ? vac_pkg::VAC_LOC_USED : vac_pkg::VAC_LOC_NONE;
    // bit 0 fixed round-robin, bit 1 wrr32; 64/128-phase bits never offered
    arb_scheme_mask = table_used ? vac_pkg::VAC_MASK_FULL : vac_pkg::VAC_MASK_NONE;
  end
  assign O_LOW_PRIO_EXT_CHANNEL_COUNT = low_prio_ext_channel_count;
  assign O_ARB_TABLE_IN_USE = table_used;
  // ****************************************************************
  // address decode
  // ****************************************************************
  logic [11:0] word_addr;
  logic hit_cap;
  logic hit_ctrl;
  logic ctrl_wr;
  logic commit_req;
  always_comb begin
    word_addr = I_CFG_REQ.addr & vac_pkg::VAC_DWORD_MASK;
    hit_cap = (word_addr == vac_pkg::VAC_CAP_ADDR);
    hit_ctrl = (word_addr == vac_pkg::VAC_CTRL_ADDR);
    // status half is read-only, so only the low control byte takes writes
    ctrl_wr = I_CFG_REQ.wr && hit_ctrl && I_CFG_REQ.be[vac_pkg::VAC_CTRL_BYTE];
    commit_req = ctrl_wr && I_CFG_REQ.wdata[vac_pkg::VAC_COMMIT_BIT];
  end
  // ****************************************************************
  // scheme choice
  // ****************************************************************
  logic [2:0] arb_scheme_choice;
  logic [2:0] next_arb_scheme_choice;
  always_comb begin
    next_arb_scheme_choice = arb_scheme_choice;
    if (ctrl_wr) begin
      // stored as written; software keeps to the supported codes
      next_arb_scheme_choice = I_CFG_REQ.wdata[vac_pkg::VAC_CHOICE_MSB:vac_pkg::VAC_CHOICE_LSB];
    end
  end
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      arb_scheme_choice <= vac_pkg::VAC_CHOICE_RESET;
    end else begin
      arb_scheme_choice <= next_arb_scheme_choice;
    end
  end
  assign O_ARB_SCHEME_CHOICE = arb_scheme_choice;
  // ****************************************************************
  // table commit and dirty tracking
  // ****************************************************************
  vac_pkg::vac_copy_e copy_state;
  vac_pkg::vac_copy_e next_copy_state;
  logic arb_table_dirty;
  logic next_arb_table_dirty;
  logic changed_in_copy;
  logic next_changed_in_copy;
  logic copy_start;
  logic next_copy_start;
  always_comb begin
    next_copy_state = copy_state;
    next_arb_table_dirty = arb_table_dirty;
    next_changed_in_copy = changed_in_copy;
    next_copy_start = 1'b0;
    case (copy_state)
      vac_pkg::VAC_COPY_IDLE: begin
        // a scratch table never reaches the internal tables
        if (commit_req && table_used) begin
          next_copy_state = vac_pkg::VAC_COPY_BUSY;
          next_copy_start = 1'b1;
          next_changed_in_copy = 1'b0;
        end
      end
      vac_pkg::VAC_COPY_BUSY: begin
        if (I_TABLE_ENTRY_WRITE) begin
          next_changed_in_copy = 1'b1;
        end
        if (I_TABLE_COPY_DONE) begin
          next_copy_state = vac_pkg::VAC_COPY_IDLE;
          next_arb_table_dirty = changed_in_copy;
          next_changed_in_copy = 1'b0;
        end
      end
      default: begin
        next_copy_state = vac_pkg::VAC_COPY_IDLE;
      end
    endcase
    // a change in the clearing cycle wins over the clear
    if (I_TABLE_ENTRY_WRITE) begin
      next_arb_table_dirty = 1'b1;
    end
  end
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      copy_state <= vac_pkg::VAC_COPY_IDLE;
      arb_table_dirty <= 1'b0;
      changed_in_copy <= 1'b0;
      copy_start <= 1'b0;
    end else begin
      copy_state <= next_copy_state;
      arb_table_dirty <= next_arb_table_dirty;
      changed_in_copy <= next_changed_in_copy;
      copy_start <= next_copy_start;
    end
  end
  assign O_TABLE_COPY_START = copy_start;
  // ****************************************************************
  // read path
  // ****************************************************************
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic [15:0] ctrl_half;
  logic [15:0] stat_half;
  always_comb begin
    ctrl_half = vac_pkg::VAC_ZERO_HALF;
    ctrl_half[vac_pkg::VAC_CHOICE_MSB:vac_pkg::VAC_CHOICE_LSB] = arb_scheme_choice;
    stat_half = vac_pkg::VAC_ZERO_HALF;
    stat_half[vac_pkg::VAC_DIRTY_BIT] = arb_table_dirty;
    next_rdata = vac_pkg::VAC_ZERO_WORD;
    next_rvalid = I_CFG_REQ.rd;
    if (I_CFG_REQ.rd && hit_cap) begin
      next_rdata[vac_pkg::VAC_LOC_LSB +: 8] = arb_table_location;
      next_rdata[vac_pkg::VAC_MASK_LSB +: 8] = arb_scheme_mask;
    end else if (I_CFG_REQ.rd && hit_ctrl) begin
      next_rdata[vac_pkg::VAC_CTRL_LSB +: 16] = ctrl_half;
      next_rdata[vac_pkg::VAC_STAT_LSB +: 16] = stat_half;
    end
  end
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      rdata <= vac_pkg::VAC_ZERO_WORD;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end
  assign O_CFG_RDATA = rdata;
  assign O_CFG_RVALID = rvalid;
  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_cap_location;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (I_CFG_REQ.rd && hit_cap) |=> (O_CFG_RDATA[31:24] == ($past(I_STRICT_PRIO_EN) ? 8'h00 : 8'h03));
  endproperty
  a_cap_location: assert property (p_cap_location) else $error("table location read wrong");
  property p_cap_mask;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (I_CFG_REQ.rd && hit_cap) |=> (O_CFG_RDATA[7:0] == ($past(I_STRICT_PRIO_EN) ? 8'h00 : 8'h03));
  endproperty
  a_cap_mask: assert property (p_cap_mask) else $error("scheme mask read wrong");
  property p_cap_reserved;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_CFG_RVALID && $past(hit_cap) |-> (O_CFG_RDATA[23:8] == 16'h0000);
  endproperty
  a_cap_reserved: assert property (p_cap_reserved) else $error("capability reserved bits set");
  property p_ctrl_reserved;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_CFG_RVALID && $past(hit_ctrl) |->
      (O_CFG_RDATA[15:4] == 12'h000) && !O_CFG_RDATA[0] && (O_CFG_RDATA[31:17] == 15'h0000);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits set");
  property p_choice_write;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctrl_wr |=> (O_ARB_SCHEME_CHOICE == $past(I_CFG_REQ.wdata[3:1]));
  endproperty
  a_choice_write: assert property (p_choice_write) else $error("scheme choice not stored");
  property p_choice_reset;
    @(posedge I_SYS_CLK) !I_RST_N |=> (O_ARB_SCHEME_CHOICE == 3'h0);
  endproperty
  a_choice_reset: assert property (p_choice_reset) else $error("scheme choice reset wrong");
  property p_commit_start;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (commit_req && table_used && copy_state == vac_pkg::VAC_COPY_IDLE) |=> O_TABLE_COPY_START ##1 !O_TABLE_COPY_START;
  endproperty
  a_commit_start: assert property (p_commit_start) else $error("copy start not pulsed");
  property p_scratch;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !table_used && copy_state == vac_pkg::VAC_COPY_IDLE |=> !O_TABLE_COPY_START;
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch table was copied");
  property p_dirty_set;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    I_TABLE_ENTRY_WRITE |=> arb_table_dirty;
  endproperty
  a_dirty_set: assert property (p_dirty_set) else $error("dirty flag not set");
  property p_dirty_hold;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    // a reset that wipes a set flag is not a clear by copy
    $fell(arb_table_dirty) && $past(I_RST_N) |->
      $past(I_TABLE_COPY_DONE) && $past(copy_state == vac_pkg::VAC_COPY_BUSY);
  endproperty
  a_dirty_hold: assert property (p_dirty_hold) else $error("dirty cleared without finished copy");
  property p_dirty_recopy;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (copy_state == vac_pkg::VAC_COPY_BUSY && I_TABLE_ENTRY_WRITE) ##1 I_TABLE_COPY_DONE |=> arb_table_dirty;
  endproperty
  a_dirty_recopy: assert property (p_dirty_recopy) else $error("change during copy lost");
  property p_prio_count;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_LOW_PRIO_EXT_CHANNEL_COUNT == (I_STRICT_PRIO_EN ? 3'h0 : 3'h1);
  endproperty
  a_prio_count: assert property (p_prio_count) else $error("low priority count wrong");
endmodule
`default_nettype wire

// File: bench/vac_arbitration_config_tb.sv
// self-checking bench for the vc arbitration configuration registers
`default_nettype none
module vac_arbitration_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic strict;
    logic [11:0] addr;
    logic [31:0] exp;
    logic use_exp;
    logic [2:0] cnt_exp;
  } vac_row_s;
  logic clk;
  logic rst_n;
  vac_pkg::vac_cfg_req_s req;
  logic [31:0] rdata;
  logic rvalid;
  logic strict;
  logic entry_wr;
  logic start;
  logic done;
  logic [2:0] choice;
  logic in_use;
  logic [2:0] count;
  int fails;
  int n_checks;
  logic [31:0] got;
  vac_row_s rows [5];
  vac_arbitration_config u_dut (
    .I_SYS_CLK(clk),
    .I_RST_N(rst_n),
    .I_CFG_REQ(req),
    .O_CFG_RDATA(rdata),
    .O_CFG_RVALID(rvalid),
    .I_STRICT_PRIO_EN(strict),
    .I_TABLE_ENTRY_WRITE(entry_wr),
    .O_TABLE_COPY_START(start),
    .I_TABLE_COPY_DONE(done),
    .O_ARB_SCHEME_CHOICE(choice),
    .O_ARB_TABLE_IN_USE(in_use),
    .O_LOW_PRIO_EXT_CHANNEL_COUNT(count)
  );
  // ****************************************************************
  // clock and helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // inputs move 1 ns after the edge so the design never races the bench
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    req.addr = a;
    req.rd = 1'b1;
    step();
    req.rd = 1'b0;
    chk("rvalid", {31'h0, rvalid}, 32'h0000_0001);
    d = rdata;
    step();
    chk("rvalid_drop", {31'h0, rvalid}, 32'h0000_0000);
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    req.addr = a;
    req.be = be;
    req.wdata = d;
    req.wr = 1'b1;
    step();
    req.wr = 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************************************************************
  // watchdog
  // ****************************************************************
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    give_verdict();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    req = '0;
    strict = 1'b0;
    entry_wr = 1'b0;
    done = 1'b0;
    rst_n = 1'b0;
    fails = 0;
    n_checks = 0;
    rows[0] = '{1'b0, 12'h158, 32'h0300_0003, 1'b1, 3'h1};
    rows[1] = '{1'b1, 12'h158, 32'h0000_0000, 1'b0, 3'h0};
    rows[2] = '{1'b0, 12'h15C, 32'h0000_0000, 1'b1, 3'h1};
    rows[3] = '{1'b0, 12'h15E, 32'h0000_0000, 1'b1, 3'h1};
    rows[4] = '{1'b0, 12'h160, 32'h0000_0000, 1'b1, 3'h1};
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("choice_reset", {29'h0, choice}, 32'h0000_0000);
    foreach (rows[i]) begin
      strict = rows[i].strict;
      rd(rows[i].addr, got);
      chk("cfg_word", got, rows[i].exp);
      chk("in_use", {31'h0, in_use}, {31'h0, rows[i].use_exp});
      chk("lp_count", {29'h0, count}, {29'h0, rows[i].cnt_exp});
    end
    // strict mode: table is scratch, so a commit must not start a copy
    strict = 1'b1;
    wr(12'h15C, 4'h1, 32'hFFFF_FFF3);
    chk("start_scratch", {31'h0, start}, 32'h0000_0000);
    chk("choice", {29'h0, choice}, 32'h0000_0001);
    // an idle edge between writes so the strobe is never raised twice in one step
    step();
    wr(12'h15C, 4'hE, 32'h0000_0000);
    step();
    wr(12'h160, 4'hF, 32'h0000_0000);
    rd(12'h15C, got);
    chk("ctrl_word", got, 32'h0000_0002);
    strict = 1'b0;
    entry_wr = 1'b1;
    step();
    entry_wr = 1'b0;
    rd(12'h15C, got);
    chk("dirty_set", got, 32'h0001_0002);
    // change in mid-copy must survive that copy's completion
    wr(12'h15C, 4'h1, 32'h0000_0003);
    chk("start", {31'h0, start}, 32'h0000_0001);
    entry_wr = 1'b1;
    step();
    entry_wr = 1'b0;
    chk("start_pulse", {31'h0, start}, 32'h0000_0000);
    done = 1'b1;
    step();
    done = 1'b0;
    rd(12'h15C, got);
    chk("dirty_kept", got, 32'h0001_0002);
    wr(12'h15C, 4'h1, 32'h0000_0003);
    chk("start2", {31'h0, start}, 32'h0000_0001);
    rd(12'h15C, got);
    chk("dirty_busy", got, 32'h0001_0002);
    done = 1'b1;
    step();
    done = 1'b0;
    rd(12'h15C, got);
    chk("dirty_clear", got, 32'h0000_0002);
    // commit while busy is dropped; change in the finishing cycle wins
    wr(12'h15C, 4'h1, 32'h0000_0003);
    chk("start3", {31'h0, start}, 32'h0000_0001);
    step();
    wr(12'h15C, 4'h1, 32'h0000_0003);
    chk("start_busy", {31'h0, start}, 32'h0000_0000);
    done = 1'b1;
    entry_wr = 1'b1;
    step();
    done = 1'b0;
    entry_wr = 1'b0;
    rd(12'h15C, got);
    chk("dirty_race", got, 32'h0001_0002);
    // second reset in mid-run
    rst_n = 1'b0;
    step();
    rst_n = 1'b1;
    chk("choice_rst2", {29'h0, choice}, 32'h0000_0000);
    rd(12'h15C, got);
    chk("ctrl_rst2", got, 32'h0000_0000);
    give_verdict();
  end
endmodule
`default_nettype wire
